// ==== rtl/ebu_defines.svh ====
// Register indices, reset values, field positions and operating modes of the external bus unit
`ifndef EBU_DEFINES_SVH
`define EBU_DEFINES_SVH

`define EBU_APB_AW 22
`define EBU_IDX_W 20

// Register indices; byte address is four times the index
`define EBU_IDX_BUS_RELEASE_CONTROL 20'hEE013
`define EBU_IDX_ADDRESS_CONTROL 20'hEE01E
`define EBU_IDX_AREA_SELECT_CONTROL 20'hEE01F
`define EBU_IDX_AREA_WIDTH_CONTROL 20'hEE020
`define EBU_IDX_AREA_STATE_CONTROL 20'hEE021
`define EBU_IDX_WAIT_CONTROL_HIGH 20'hEE022
`define EBU_IDX_WAIT_CONTROL_LOW 20'hEE023
`define EBU_IDX_GENERAL_BUS_CONTROL 20'hEE024

// Reset values
`define EBU_RST_BUS_RELEASE_CONTROL 8'hFE
`define EBU_RST_ADDRESS_CONTROL 8'hFF
`define EBU_RST_AREA_SELECT_CONTROL 8'h0F
`define EBU_RST_WIDTH_NARROW 8'hFF
`define EBU_RST_WIDTH_WIDE 8'h00
`define EBU_RST_AREA_STATE_CONTROL 8'hFF
`define EBU_RST_WAIT_CONTROL 8'hFF
`define EBU_RST_GENERAL_BUS_CONTROL 8'hC6

// Field positions
`define EBU_BRC_RELEASE_EN 0
`define EBU_GBC_IDLE_READ_AREA 2
`define EBU_GBC_IDLE_READ_WRITE 1
`define EBU_AREA_LSB_1M 17
`define EBU_AREA_LSB_16M 21

// Operating modes
`define EBU_MODE_WIDE_A 3'h2
`define EBU_MODE_WIDE_B 3'h4
`define EBU_MODE_SINGLE_A 3'h6
`define EBU_MODE_SINGLE_B 3'h7

`endif

// ==== rtl/ebu_pkg.sv ====
// Types shared by the external bus unit
package ebu_pkg;

    typedef struct packed {
        logic onChip;
        logic write;
        logic word;
        logic [23:0] addr;
        logic [15:0] wdata;
    } ebu_req_t;

    typedef struct packed {
        logic [7:0] areaSelectN;
        logic addressStrobeN;
        logic readStrobeN;
        logic highByteWriteStrobeN;
        logic lowByteWriteStrobeN;
        logic [23:0] addr;
        logic [15:0] dout;
        logic busOe;
        logic dataOe;
    } ebu_pins_t;

    typedef enum logic [3:0] {
        S_IDLE, S_GAP, S_T1, S_T2, S_TW, S_T3, S_INT, S_DONE, S_REL
    } ebu_state_t;

endpackage : ebu_pkg

// ==== rtl/ebu_sync.sv ====
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module ebu_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            meta <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta <= d;
            q <= meta;
        end
    end

endmodule : ebu_sync

`default_nettype wire

// ==== rtl/ebu_top.sv ====
// External bus unit: area decode, access timing, strobes, bus release and APB registers
//
// Contract
// - External space is eight areas, 128 kbytes or 2 Mbytes each by address mode
// - One active-low select per area, asserted for the accessed area
// - Address strobe low while a valid external address is driven
// - Read strobe low during every external read cycle
// - High write strobe for data on 15..8, low write strobe for 7..0
// - Wait request input lengthens only three-state area accesses
// - Bus request releases the bus, acknowledge shows the release
// - Arbiter gives the bus to the processor or an external master
// - Optional idle cycle between reads to different areas
// - Optional idle cycle when a read is directly followed by a write
// - Width bit n: 0 makes area n 16-bit, 1 makes it 8-bit
// - All width bits one gives 8-bit bus mode and frees port 4
// - Width register resets to ones, or zeros in modes 2 and 4
// - State bit n: 0 two-state, 1 three-state; all ones after reset
// - State register set to ones on reset and hardware standby
// - Both wait registers set to ones on reset and hardware standby
// - Wait registers pick per-area program wait states for external accesses
// - On-chip accesses fixed; settings void in single-chip modes 6 and 7
// - Wait code gives 0 to 3 waits, only in three-state areas
// - High wait register holds areas 7..4, low holds 3..0, from bit 7
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ebu_defines.svh"

module ebu_top (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`EBU_APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] modePin,
    input wire logic bigAddrPin,
    input wire logic hwStandbyN,
    input wire logic cpuValid,
    input wire ebu_pkg::ebu_req_t cpuReq,
    output logic cpuDone,
    output logic [15:0] cpuRdata,
    output ebu_pkg::ebu_pins_t extPins,
    input wire logic [15:0] dataIn,
    input wire logic waitRequestN,
    input wire logic busTakeRequestN,
    output logic busAckN,
    output logic bus16Mode,
    output logic port4Gpio
);
    import ebu_pkg::*;

    typedef enum logic [3:0] {
        D_NONE, D_BRC, D_ADRC, D_ASEL, D_WIDTH, D_STATE, D_WCH, D_WCL, D_GBC
    } ebu_dec_t;

    // Decode an APB byte address to a register
    function automatic ebu_dec_t decode(input logic [`EBU_APB_AW-1:0] a);
        logic [`EBU_IDX_W-1:0] idx;
        idx = a[`EBU_APB_AW-1:2];
        decode = D_NONE;
        if (a[1:0] == 2'h0) begin
            unique case (idx)
                `EBU_IDX_BUS_RELEASE_CONTROL: decode = D_BRC;
                `EBU_IDX_ADDRESS_CONTROL: decode = D_ADRC;
                `EBU_IDX_AREA_SELECT_CONTROL: decode = D_ASEL;
                `EBU_IDX_AREA_WIDTH_CONTROL: decode = D_WIDTH;
                `EBU_IDX_AREA_STATE_CONTROL: decode = D_STATE;
                `EBU_IDX_WAIT_CONTROL_HIGH: decode = D_WCH;
                `EBU_IDX_WAIT_CONTROL_LOW: decode = D_WCL;
                `EBU_IDX_GENERAL_BUS_CONTROL: decode = D_GBC;
                default: decode = D_NONE;
            endcase
        end
    endfunction : decode

    logic [2:0] mode;
    logic bigAddr;
    logic hwStandbyNs;
    logic [15:0] dataSync;
    logic waitSync;
    logic takeSync;

    ebu_sync #(.W(3), .RST_VAL(3'h0)) uSyncMode (
        .clk(clk), .rstn(1'b1), .d(modePin), .q(mode)
    );
    ebu_sync #(.W(1), .RST_VAL(1'b0)) uSyncBig (
        .clk(clk), .rstn(rstn), .d(bigAddrPin), .q(bigAddr)
    );
    ebu_sync #(.W(1), .RST_VAL(1'b1)) uSyncHws (
        .clk(clk), .rstn(rstn), .d(hwStandbyN), .q(hwStandbyNs)
    );
    ebu_sync #(.W(16), .RST_VAL(16'h0000)) uSyncData (
        .clk(clk), .rstn(rstn), .d(dataIn), .q(dataSync)
    );
    ebu_sync #(.W(1), .RST_VAL(1'b1)) uSyncWait (
        .clk(clk), .rstn(rstn), .d(waitRequestN), .q(waitSync)
    );
    ebu_sync #(.W(1), .RST_VAL(1'b1)) uSyncTake (
        .clk(clk), .rstn(rstn), .d(busTakeRequestN), .q(takeSync)
    );

    logic [7:0] busReleaseControl;
    logic [7:0] addressControl;
    logic [7:0] areaSelectControl;
    logic [7:0] areaWidthControl;
    logic [7:0] areaStateControl;
    logic [7:0] waitControlHigh;
    logic [7:0] waitControlLow;
    logic [7:0] generalBusControl;

    logic init;
    logic wideMode;
    logic singleChip;
    logic apbWrite;
    ebu_dec_t wrSel;

    assign init = !rstn || !hwStandbyNs;
    assign wideMode = (mode == `EBU_MODE_WIDE_A) || (mode == `EBU_MODE_WIDE_B);
    assign singleChip = (mode == `EBU_MODE_SINGLE_A) || (mode == `EBU_MODE_SINGLE_B);
    assign apbWrite = psel && penable && pwrite;
    assign wrSel = decode(paddr);

    // Register writes; reset and hardware standby initialise, APB writes load otherwise
    always_ff @(posedge clk) begin
        if (init) begin
            busReleaseControl <= `EBU_RST_BUS_RELEASE_CONTROL;
            addressControl <= `EBU_RST_ADDRESS_CONTROL;
            areaSelectControl <= `EBU_RST_AREA_SELECT_CONTROL;
            areaWidthControl <= wideMode ? `EBU_RST_WIDTH_WIDE : `EBU_RST_WIDTH_NARROW;
            areaStateControl <= `EBU_RST_AREA_STATE_CONTROL;
            waitControlHigh <= `EBU_RST_WAIT_CONTROL;
            waitControlLow <= `EBU_RST_WAIT_CONTROL;
            generalBusControl <= `EBU_RST_GENERAL_BUS_CONTROL;
        end else if (apbWrite) begin
            unique case (wrSel)
                D_BRC: busReleaseControl <= pwdata[7:0];
                D_ADRC: addressControl <= pwdata[7:0];
                D_ASEL: areaSelectControl <= pwdata[7:0];
                D_WIDTH: areaWidthControl <= pwdata[7:0];
                D_STATE: areaStateControl <= pwdata[7:0];
                D_WCH: waitControlHigh <= pwdata[7:0];
                D_WCL: waitControlLow <= pwdata[7:0];
                D_GBC: generalBusControl <= pwdata[7:0];
                D_NONE: ;
            endcase
        end
    end

    // Read data and error taken in the setup phase, shown in the access phase
    always_ff @(posedge clk) begin
        if (!rstn) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pslverr <= (decode(paddr) == D_NONE);
            unique case (decode(paddr))
                D_BRC: prdata <= {24'h000000, busReleaseControl};
                D_ADRC: prdata <= {24'h000000, addressControl};
                D_ASEL: prdata <= {24'h000000, areaSelectControl};
                D_WIDTH: prdata <= {24'h000000, areaWidthControl};
                D_STATE: prdata <= {24'h000000, areaStateControl};
                D_WCH: prdata <= {24'h000000, waitControlHigh};
                D_WCL: prdata <= {24'h000000, waitControlLow};
                D_GBC: prdata <= {24'h000000, generalBusControl};
                D_NONE: prdata <= 32'h00000000;
            endcase
        end
    end

    assign pready = 1'b1;

    assign port4Gpio = &areaWidthControl;
    assign bus16Mode = !port4Gpio;

    // Area decode and per-area settings of the current request
    logic [2:0] area;
    logic narrow;
    logic three;
    logic [1:0] waitCode;
    logic [15:0] waitAll;
    logic external;

    assign area = bigAddr ? cpuReq.addr[`EBU_AREA_LSB_16M +: 3]
                          : cpuReq.addr[`EBU_AREA_LSB_1M +: 3];
    assign narrow = areaWidthControl[area];
    assign three = areaStateControl[area];
    assign waitAll = {waitControlHigh, waitControlLow};
    assign waitCode = waitAll[{area, 1'b0} +: 2];
    assign external = !cpuReq.onChip && !singleChip;

    ebu_state_t state;
    ebu_state_t next_state;
    logic half;
    logic next_half;
    logic [1:0] waitCnt;
    logic lastRead;
    logic [2:0] lastArea;
    logic needGap;
    logic twoHalves;
    logic cycleEnd;

    assign twoHalves = cpuReq.word && narrow;
    assign needGap = lastRead
        && ((generalBusControl[`EBU_GBC_IDLE_READ_AREA] && !cpuReq.write
             && area != lastArea)
            || (generalBusControl[`EBU_GBC_IDLE_READ_WRITE] && cpuReq.write));
    assign cycleEnd = (state == S_T3) || (state == S_T2 && !three);

    // Next state of the access sequencer and arbiter
    always_comb begin
        next_state = state;
        next_half = half;
        unique case (state)
            S_IDLE: begin
                next_half = 1'b0;
                if (busReleaseControl[`EBU_BRC_RELEASE_EN] && !takeSync) begin
                    next_state = S_REL;
                end else if (cpuValid) begin
                    if (!external) begin
                        next_state = S_INT;
                    end else if (needGap) begin
                        next_state = S_GAP;
                    end else begin
                        next_state = S_T1;
                    end
                end
            end
            S_GAP: next_state = S_T1;
            S_T1: next_state = S_T2;
            S_T2: begin
                if (!three) begin
                    next_state = S_DONE;
                end else if (waitCnt != 2'h0 || !waitSync) begin
                    next_state = S_TW;
                end else begin
                    next_state = S_T3;
                end
            end
            S_TW: begin
                if (waitCnt == 2'h0 && waitSync) begin
                    next_state = S_T3;
                end
            end
            S_T3: next_state = S_DONE;
            S_INT: next_state = S_DONE;
            S_DONE: next_state = S_IDLE;
            S_REL: begin
                if (takeSync) begin
                    next_state = S_IDLE;
                end
            end
        endcase
        if (cycleEnd && twoHalves && !half) begin
            next_state = S_T1;
            next_half = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state <= S_IDLE;
            half <= 1'b0;
        end else begin
            state <= next_state;
            half <= next_half;
        end
    end

    // Program wait counter, loaded at T1 for three-state areas only
    always_ff @(posedge clk) begin
        if (!rstn) begin
            waitCnt <= 2'h0;
        end else if (next_state == S_T1) begin
            waitCnt <= three ? waitCode : 2'h0;
        end else if ((state == S_T2 || state == S_TW) && waitCnt != 2'h0) begin
            waitCnt <= waitCnt - 2'h1;
        end
    end

    // History of the last external cycle for idle insertion
    always_ff @(posedge clk) begin
        if (!rstn) begin
            lastRead <= 1'b0;
            lastArea <= 3'h0;
        end else if (cycleEnd) begin
            lastRead <= !cpuReq.write;
            lastArea <= area;
        end else if (state == S_IDLE || state == S_REL || state == S_INT) begin
            lastRead <= 1'b0;
        end
    end

    // Read data capture one state after the cycle ends, behind the two data flops
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cpuRdata <= 16'h0000;
        end else if (!cpuReq.write && external && (state == S_DONE || (state == S_T1 && half))) begin
            if (narrow && cpuReq.word) begin
                if (state == S_DONE) begin
                    cpuRdata[7:0] <= dataSync[15:8];
                end else begin
                    cpuRdata[15:8] <= dataSync[15:8];
                end
            end else if (cpuReq.word) begin
                cpuRdata <= dataSync;
            end else if (narrow || !cpuReq.addr[0]) begin
                cpuRdata <= {8'h00, dataSync[15:8]};
            end else begin
                cpuRdata <= {8'h00, dataSync[7:0]};
            end
        end else if (state == S_INT) begin
            cpuRdata <= 16'h0000;
        end
    end

    assign cpuDone = (state == S_DONE);

    // Pin drive, registered from the next state
    logic active;
    logic writePhase;
    logic hiLane;
    logic loLane;

    assign active = (next_state == S_T1) || (next_state == S_T2)
                 || (next_state == S_TW) || (next_state == S_T3);
    assign writePhase = cpuReq.write && ((next_state == S_TW) || (next_state == S_T3)
        || (next_state == S_T2 && (three || state == S_T1)));
    assign hiLane = narrow || cpuReq.word || !cpuReq.addr[0];
    assign loLane = !narrow && (cpuReq.word || cpuReq.addr[0]);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            extPins.areaSelectN <= 8'hFF;
            extPins.addressStrobeN <= 1'b1;
            extPins.readStrobeN <= 1'b1;
            extPins.highByteWriteStrobeN <= 1'b1;
            extPins.lowByteWriteStrobeN <= 1'b1;
            extPins.addr <= 24'h000000;
            extPins.dout <= 16'h0000;
            extPins.busOe <= 1'b1;
            extPins.dataOe <= 1'b0;
            busAckN <= 1'b1;
        end else begin
            extPins.areaSelectN <= active ? ~(8'h01 << area) : 8'hFF;
            extPins.addressStrobeN <= !active;
            extPins.readStrobeN <= !(active && !cpuReq.write);
            extPins.highByteWriteStrobeN <= !(writePhase && hiLane);
            extPins.lowByteWriteStrobeN <= !(writePhase && loLane);
            if (active) begin
                extPins.addr <= {cpuReq.addr[23:1], cpuReq.addr[0] | next_half};
            end
            if (narrow && cpuReq.word) begin
                extPins.dout <= next_half ? {cpuReq.wdata[7:0], 8'h00}
                                          : {cpuReq.wdata[15:8], 8'h00};
            end else if (cpuReq.word) begin
                extPins.dout <= cpuReq.wdata;
            end else begin
                extPins.dout <= {cpuReq.wdata[7:0], cpuReq.wdata[7:0]};
            end
            extPins.busOe <= (next_state != S_REL);
            extPins.dataOe <= active && cpuReq.write;
            busAckN <= (next_state != S_REL);
        end
    end

endmodule : ebu_top

`default_nettype wire

// ==== tb/ebu_top_chk.sv ====
// Checker of the external bus unit pin relations
`timescale 1ns/1ps
`default_nettype none
module ebu_top_chk (
    input wire logic clk,
    input wire logic rstn,
    input wire logic bigAddrPin,
    input wire logic busTakeRequestN,
    input wire logic busAckN,
    input wire logic bus16Mode,
    input wire logic port4Gpio,
    input wire ebu_pkg::ebu_pins_t extPins
);
    import ebu_pkg::*;
    logic [2:0] area;
    logic wrLow;
    assign area = bigAddrPin ? extPins.addr[23:21] : extPins.addr[19:17];
    assign wrLow = !(extPins.highByteWriteStrobeN && extPins.lowByteWriteStrobeN);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    a_one_select: assert property ($onehot0(~extPins.areaSelectN))
        else $error("several area selects low");
    a_area_decode: assert property (
        !extPins.addressStrobeN |-> (~extPins.areaSelectN) == (8'h01 << area))
        else $error("select does not match address area");
    a_read_addr: assert property (
        !extPins.readStrobeN |-> !extPins.addressStrobeN && extPins.busOe)
        else $error("read strobe without address strobe");
    a_write_data: assert property (
        wrLow |-> extPins.dataOe && extPins.areaSelectN != 8'hFF)
        else $error("write strobe without driven data");
    a_rd_wr_excl: assert property (!extPins.readStrobeN |-> !wrLow)
        else $error("read and write strobes together");
    a_ack_release: assert property (
        !busAckN |-> !extPins.busOe && extPins.areaSelectN == 8'hFF)
        else $error("bus acknowledged while still driven");
    a_ack_request: assert property ($fell(busAckN) |-> !busTakeRequestN)
        else $error("bus released without request");
    a_ack_return: assert property ($rose(busTakeRequestN) |-> ##[1:6] busAckN)
        else $error("bus not taken back");
    a_width_mode: assert property (
        port4Gpio |-> !bus16Mode && extPins.lowByteWriteStrobeN)
        else $error("low byte lane used in 8-bit bus mode");
    c_read: cover property (!extPins.readStrobeN);
    c_word_write: cover property (!extPins.highByteWriteStrobeN && !extPins.lowByteWriteStrobeN);
    c_release: cover property (!busAckN);
endmodule : ebu_top_chk
bind ebu_top ebu_top_chk u_chk (.clk, .rstn, .bigAddrPin, .busTakeRequestN, .busAckN,
    .bus16Mode, .port4Gpio, .extPins);
`default_nettype wire

// ==== tb/ebu_ext_model.sv ====
// Behavioural external memory with a wait pin, beyond the bus pins
`timescale 1ns/1ps
`default_nettype none
module ebu_ext_model (
    input wire logic clk,
    input wire ebu_pkg::ebu_pins_t extPins,
    input wire logic [3:0] pinWaits,
    output logic [15:0] dataIn,
    output logic waitRequestN
);
    import ebu_pkg::*;
    logic [7:0] mem [256];
    logic [7:0] a;
    logic [15:0] lastOut;
    logic [3:0] waitCnt;
    logic selected;
    assign a = extPins.addr[7:0];
    assign selected = extPins.areaSelectN != 8'hFF;
    // Released data bus toggles so a stale value is never read
    assign dataIn = (selected && !extPins.readStrobeN) ? {mem[a], mem[a | 8'h01]} : ~lastOut;
    // Slow device holds wait until it has seen enough selected cycles
    assign waitRequestN = waitCnt >= pinWaits;
    initial begin
        lastOut = 16'h0000;
        waitCnt = 4'h0;
        foreach (mem[i]) mem[i] = 8'h00;
    end
    always @(posedge clk) begin
        lastOut <= dataIn;
        if (!selected) waitCnt <= 4'h0;
        else if (waitCnt != 4'hF) waitCnt <= waitCnt + 4'h1;
        if (!extPins.highByteWriteStrobeN) mem[a] <= extPins.dout[15:8];
        if (!extPins.lowByteWriteStrobeN) mem[a | 8'h01] <= extPins.dout[7:0];
    end
endmodule : ebu_ext_model
`default_nettype wire

// ==== tb/tb_external_area_bus_controller.sv ====
// Self-checking bench of the external bus unit
`timescale 1ns/1ps
`default_nettype none
`include "ebu_defines.svh"
module tb_external_area_bus_controller;
    import ebu_pkg::*;
    logic clk, rstn, psel, penable, pwrite, pready, pslverr, err, flag, wd;
    logic [`EBU_APB_AW-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] modePin, ar;
    logic bigAddrPin, hwStandbyN, cpuValid, cpuDone, waitRequestN;
    logic busTakeRequestN, busAckN, bus16Mode, port4Gpio;
    logic [15:0] cpuRdata, dataIn, wc, dw;
    logic [7:0] st, wb, off;
    logic [3:0] pinWaits;
    ebu_req_t cpuReq;
    ebu_pins_t extPins;
    int n_fail, check_count, n;
    logic [19:0] idxTab [8] = '{`EBU_IDX_BUS_RELEASE_CONTROL, `EBU_IDX_ADDRESS_CONTROL,
        `EBU_IDX_AREA_SELECT_CONTROL, `EBU_IDX_AREA_WIDTH_CONTROL, `EBU_IDX_AREA_STATE_CONTROL,
        `EBU_IDX_WAIT_CONTROL_HIGH, `EBU_IDX_WAIT_CONTROL_LOW, `EBU_IDX_GENERAL_BUS_CONTROL};
    logic [7:0] rstTab [8] = '{`EBU_RST_BUS_RELEASE_CONTROL, `EBU_RST_ADDRESS_CONTROL,
        `EBU_RST_AREA_SELECT_CONTROL, `EBU_RST_WIDTH_NARROW, `EBU_RST_AREA_STATE_CONTROL,
        `EBU_RST_WAIT_CONTROL, `EBU_RST_WAIT_CONTROL, `EBU_RST_GENERAL_BUS_CONTROL};

    ebu_top uut (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .modePin, .bigAddrPin, .hwStandbyN, .cpuValid, .cpuReq, .cpuDone, .cpuRdata,
        .extPins, .dataIn, .waitRequestN, .busTakeRequestN, .busAckN, .bus16Mode, .port4Gpio);
    ebu_ext_model u_mem (.clk, .extPins, .pinWaits, .dataIn, .waitRequestN);

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : close_out

    task automatic reset_dut(input logic [2:0] m);
        rstn <= 1'b0;
        modePin <= m;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
    endtask : reset_dut

    task automatic apb(input logic wr, input logic [19:0] idx, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic cpu(input logic oc, w, wde, input logic [23:0] a, input logic [15:0] d,
        input logic keep);
        cpuValid <= 1'b1;
        cpuReq <= '{oc, w, wde, a, d};
        @(posedge clk);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (cpuDone !== 1'b1);
        if (!keep) begin
            cpuValid <= 1'b0;
            @(posedge clk);
        end
    endtask : cpu

    function automatic logic [23:0] addrOf(input logic [2:0] a, input logic [7:0] o);
        return {4'h0, a, 9'h000, o};
    endfunction : addrOf

    function automatic int lat(input logic [7:0] s, input logic [15:0] w, input logic [2:0] a);
        return s[a] ? 4 + int'(w[2 * a +: 2]) : 3;
    endfunction : lat

    initial begin
        {rstn, psel, penable, pwrite, cpuValid, bigAddrPin} = 6'h00;
        {hwStandbyN, busTakeRequestN} = 2'h3;
        {paddr, pwdata, cpuReq, pinWaits} = '0;
        modePin = 3'h1;
        n_fail = 0;
        check_count = 0;
        void'($urandom(10095));
        @(posedge clk);
        for (int m = 1; m < 8; m++) begin
            reset_dut(m[2:0]);
            flag = m == 2 || m == 4;
            apb(0, idxTab[3], 8'h00);
            check(rd, flag ? `EBU_RST_WIDTH_WIDE : `EBU_RST_WIDTH_NARROW);
            check(bus16Mode, flag);
            if (m == 6) begin
                cpu(0, 0, 0, addrOf(3'h0, 8'h00), 16'h0000, 0);
                check(n, 2);
            end
        end
        reset_dut(3'h1);
        for (int k = 0; k < 8; k++) begin
            apb(0, idxTab[k], 8'h00);
            check(rd, {24'h000000, rstTab[k]});
        end
        apb(1, 20'hEE025, 8'h00);
        check(err, 1'b1);
        apb(1, idxTab[3], 8'h00);
        check(port4Gpio, 1'b0);
        apb(1, idxTab[4], 8'h00);
        apb(1, idxTab[5], 8'h00);
        hwStandbyN <= 1'b0;
        repeat (5) @(posedge clk);
        hwStandbyN <= 1'b1;
        repeat (3) @(posedge clk);
        for (int k = 3; k < 6; k++) begin
            apb(0, idxTab[k], 8'h00);
            check(rd, 32'h000000FF);
        end
        cpu(1, 0, 0, addrOf(3'h5, 8'h00), 16'h0000, 0);
        check(n, 2);
        apb(1, idxTab[7], 8'h00);
        repeat (24) begin
            {st, wb, wc} = $urandom;
            {ar, wd, off} = 12'($urandom);
            dw = 16'($urandom);
            if (wd) off[0] = 1'b0;
            apb(1, idxTab[3], wb);
            apb(1, idxTab[4], st);
            apb(1, idxTab[5], wc[15:8]);
            apb(1, idxTab[6], wc[7:0]);
            apb(0, idxTab[4], 8'h00);
            check(rd, {24'h000000, st});
            cpu(0, 1, wd, addrOf(ar, off), dw, 0);
            if (!(wd && wb[ar])) check(n, lat(st, wc, ar));
            cpu(0, 0, wd, addrOf(ar, off), 16'h0000, 0);
            if (!(wd && wb[ar])) check(n, lat(st, wc, ar));
            check({wd ? cpuRdata[15:8] : 8'h00, cpuRdata[7:0]}, wd ? dw : dw[7:0]);
        end
        apb(1, idxTab[4], 8'h00);
        for (int k = 0; k < 2; k++) begin
            flag = k == 0;
            apb(1, idxTab[7], flag ? `EBU_RST_GENERAL_BUS_CONTROL : 8'h00);
            cpu(0, 0, 0, addrOf(3'h1, 8'h10), 16'h0000, 1);
            cpu(0, 0, 0, addrOf(3'h2, 8'h10), 16'h0000, 1);
            check(n, 3 + int'(flag));
            cpu(0, 0, 0, addrOf(3'h2, 8'h11), 16'h0000, 1);
            check(n, 3);
            cpu(0, 1, 0, addrOf(3'h2, 8'h12), 16'h005A, 0);
            check(n, 3 + int'(flag));
        end
        apb(1, idxTab[4], 8'h01);
        apb(1, idxTab[6], 8'h00);
        pinWaits <= 4'h8;
        cpu(0, 0, 0, addrOf(3'h1, 8'h00), 16'h0000, 0);
        check(n, 3);
        cpu(0, 0, 0, addrOf(3'h0, 8'h00), 16'h0000, 0);
        check(n > 4, 1'b1);
        pinWaits <= 4'h0;
        busTakeRequestN <= 1'b0;
        repeat (8) @(posedge clk);
        check(busAckN, 1'b1);
        busTakeRequestN <= 1'b1;
        repeat (4) @(posedge clk);
        apb(1, idxTab[0], 8'hFF);
        busTakeRequestN <= 1'b0;
        n = 0;
        while (busAckN !== 1'b0 && n < 10) begin
            @(posedge clk);
            n++;
        end
        @(posedge clk);
        check({busAckN, extPins.busOe}, 2'h0);
        busTakeRequestN <= 1'b1;
        repeat (6) @(posedge clk);
        check({busAckN, extPins.busOe}, 2'h3);
        close_out();
    end

    initial begin
        repeat (40000) @(posedge clk);
        n_fail++;
        close_out();
    end
endmodule : tb_external_area_bus_controller
`default_nettype wire
